//--- common/ctc_pkg.sv
`default_nettype none
package ctc_pkg;
   // system clock rate
   localparam int CLK_MHZ = 250;
   // register bus
   localparam int          ADDR_W     = 8;
   localparam int          DATA_W     = 32;
   localparam logic [7:0]  REG_CTRL   = 8'h00;   // control, read/write
   localparam logic [7:0]  REG_STATUS = 8'h04;   // status, read; write 1 clears mark
   localparam logic [7:0]  REG_TX     = 8'h08;   // outbound byte, write
   localparam logic [7:0]  REG_RX     = 8'h0c;   // inbound byte, read clears flag
   localparam logic [7:0]  REG_TRIG   = 8'h10;   // any write fires strobe trigger
   // control register fields
   localparam int          CTRL_W     = 6;
   localparam logic [5:0]  CTRL_RST   = 6'h00;
   localparam int          CB_BACK    = 0;       // backward_travel
   localparam int          CB_RECSEL  = 1;       // record path select
   localparam int          CB_PERMIT  = 2;       // tape_record_permit
   localparam int          CB_MOTOR   = 3;       // run the motor
   localparam int          CB_GAP     = 4;       // gap_record_request
   localparam int          CB_FAST    = 5;       // 90 ips instead of 30
   // status register fields
   localparam int          STAT_W     = 11;
   localparam int          SB_HALT    = 0;
   localparam int          SB_SPEED   = 1;
   localparam int          SB_PROT    = 2;
   localparam int          SB_MORE    = 3;
   localparam int          SB_BYTE    = 4;
   localparam int          SB_MARK    = 5;
   localparam int          SB_TIMER   = 6;
   localparam int          SB_BOT     = 7;
   localparam int          SB_LOAD    = 8;
   localparam int          SB_EW      = 9;
   localparam int          SB_HOLE    = 10;
   // synchronised pins
   localparam int          SYNC_W     = 5;
   localparam logic [4:0]  SYNC_RST   = 5'h00;
   localparam int          PIN_TICK   = 0;
   localparam int          PIN_RCLK   = 1;
   localparam int          PIN_RDAT   = 2;
   localparam int          PIN_PROT   = 3;
   localparam int          PIN_HOLE   = 4;
   // timing
   localparam int          TIMER_US   = 40;
   localparam int          TIMER_CYC_DFLT = TIMER_US * CLK_MHZ;
   localparam int          STEP_US    = 1000;    // motor ramp: 10 ips per step
   localparam int          STEP_CYC_DFLT  = STEP_US * CLK_MHZ;
   localparam int          GAP_NS     = 8000;    // least quiet time of a gap
   localparam int          GAP_CYC    = (GAP_NS * CLK_MHZ + 999) / 1000;
   localparam logic [3:0]  SPEED_SLOW = 4'h3;    // 30 ips
   localparam logic [3:0]  SPEED_FAST = 4'h9;    // 90 ips
   localparam logic [2:0]  MARK_GAPS  = 3'h4;
   localparam logic [2:0]  BIT_LAST   = 3'h7;
endpackage
`default_nettype wire

//--- common/ctc_links_if.sv
`timescale 1ns/1ns
`default_nettype none
// write serialiser link
interface ctc_wr_if;
   logic       tick_fall;          // base tick falling edge, one cycle
   logic       active;             // write path fully permitted
   logic [7:0] tape_out_byte_bus;  // byte from processor
   logic       tx_we;              // byte strobe
   logic       more_req;           // holding byte empty
   logic       wdata;              // serial bit
   logic       busy;               // shift register holds a byte
   modport ctrl (output tick_fall, active, tape_out_byte_bus, tx_we, input more_req, wdata, busy);
   modport ser  (input tick_fall, active, tape_out_byte_bus, tx_we, output more_req, wdata, busy);
endinterface

// read deserialiser link
interface ctc_rd_if;
   logic       rise;               // read clock rising edge, one cycle
   logic       bit_val;            // synchronised read data
   logic       read_mode;          // read circuits selected
   logic       ack_byte;           // processor took the byte
   logic       clr_mark;           // processor clears boundary flag
   logic [7:0] in_byte;
   logic       assembled;
   logic       mark;
   modport ctrl (output rise, bit_val, read_mode, ack_byte, clr_mark, input in_byte, assembled, mark);
   modport des  (input rise, bit_val, read_mode, ack_byte, clr_mark, output in_byte, assembled, mark);
endinterface
`default_nettype wire

//--- rtl/ctc_wr_ser.sv
`timescale 1ns/1ns
`default_nettype none
module ctc_wr_ser (
   // clock and reset
   input  wire logic clk_sys,
   input  wire logic resetn,
   // link to control
   ctc_wr_if.ser     wr
);
   logic [7:0] hold_r;      // byte waiting for the shifter
   logic       hold_full_r;
   logic [7:0] sr_r;        // parallel-in serial-out
   logic [2:0] bitcnt_r;
   logic       busy_r;
   logic       load_w;

   // reload when idle or when the last bit leaves, only if permitted
   assign load_w = hold_full_r && wr.active &&
                   (!busy_r || (wr.tick_fall && bitcnt_r == ctc_pkg::BIT_LAST));

   // holding byte: a write while full is ignored
   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         hold_r      <= 8'h00;
         hold_full_r <= 1'b0;
      end else if (wr.tx_we && !hold_full_r) begin
         hold_r      <= wr.tape_out_byte_bus;
         hold_full_r <= 1'b1;
      end else if (load_w) begin
         hold_full_r <= 1'b0;
      end
   end

   // shifter: msb first, one bit per base tick fall
   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         sr_r     <= 8'h00;
         bitcnt_r <= 3'h0;
         busy_r   <= 1'b0;
      end else if (load_w) begin
         sr_r     <= hold_r;
         bitcnt_r <= 3'h0;
         busy_r   <= 1'b1;
      end else if (wr.tick_fall && busy_r && wr.active) begin
         sr_r     <= {sr_r[6:0], 1'b0};
         bitcnt_r <= bitcnt_r + 3'h1;
         if (bitcnt_r == ctc_pkg::BIT_LAST) begin
            busy_r <= 1'b0;
         end
      end
   end

   // request only while writing is allowed
   assign wr.more_req = !hold_full_r && wr.active;
   assign wr.wdata    = sr_r[7];
   assign wr.busy     = busy_r;
endmodule
`default_nettype wire

//--- rtl/ctc_rd_des.sv
`timescale 1ns/1ns
`default_nettype none
module ctc_rd_des (
   // clock and reset
   input  wire logic clk_sys,
   input  wire logic resetn,
   // link to control
   ctc_rd_if.des     rd
);
   logic [11:0] quiet_r;    // cycles since last flux reversal
   logic        gap_w;      // one pulse per gap
   logic [1:0]  edges_r;    // reversals since last gap, saturating
   logic [2:0]  run_r;      // consecutive qualifying gaps
   logic [7:0]  sh_r;
   logic [2:0]  bitcnt_r;
   logic [7:0]  byte_r;
   logic        asm_r;
   logic        mark_r;

   assign gap_w = rd.read_mode && (quiet_r == 12'(ctc_pkg::GAP_CYC - 1));

   // quiet timer, restarted by each read clock rise
   always_ff @(posedge clk_sys) begin
      if (!resetn || rd.rise || !rd.read_mode) begin
         quiet_r <= 12'h000;
      end else if (quiet_r != 12'(ctc_pkg::GAP_CYC)) begin
         quiet_r <= quiet_r + 12'h001;
      end
   end

   // gap run: one reversal between neighbouring gaps
   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         edges_r <= 2'h0;
         run_r   <= 3'h0;
      end else if (gap_w) begin
         edges_r <= 2'h0;
         if (run_r != 3'h0 && edges_r != 2'h1) begin
            run_r <= 3'h1;
         end else if (run_r + 3'h1 == ctc_pkg::MARK_GAPS) begin
            run_r <= 3'h0;
         end else begin
            run_r <= run_r + 3'h1;
         end
      end else if (rd.rise && rd.read_mode && edges_r != 2'h3) begin
         edges_r <= edges_r + 2'h1;
      end
   end

   // boundary flag: a set beats the clear
   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         mark_r <= 1'b0;
      end else if (gap_w && run_r + 3'h1 == ctc_pkg::MARK_GAPS &&
                   (run_r == 3'h0 || edges_r == 2'h1)) begin
         mark_r <= 1'b1;
      end else if (rd.clr_mark) begin
         mark_r <= 1'b0;
      end
   end

   // serial to parallel; a gap realigns the byte
   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         sh_r     <= 8'h00;
         bitcnt_r <= 3'h0;
         byte_r   <= 8'h00;
      end else if (gap_w) begin
         bitcnt_r <= 3'h0;
      end else if (rd.rise && rd.read_mode) begin
         sh_r     <= {sh_r[6:0], rd.bit_val};
         bitcnt_r <= bitcnt_r + 3'h1;
         if (bitcnt_r == ctc_pkg::BIT_LAST) begin
            byte_r <= {sh_r[6:0], rd.bit_val};
         end
      end
   end

   // byte flag: set on eighth bit, cleared by the fetch
   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         asm_r <= 1'b0;
      end else if (!gap_w && rd.rise && rd.read_mode && bitcnt_r == ctc_pkg::BIT_LAST) begin
         asm_r <= 1'b1;
      end else if (rd.ack_byte) begin
         asm_r <= 1'b0;
      end
   end

   assign rd.in_byte   = byte_r;
   assign rd.assembled = asm_r;
   assign rd.mark      = mark_r;
endmodule
`default_nettype wire

//--- rtl/ctc_top.sv
`timescale 1ns/1ns
`default_nettype none
// How it works
// - backward_travel high moves tape backward
// - four gaps, one reversal apart, flag boundary
// - read bytes go to inbound byte bus
// - write bytes come from outbound byte bus
// - write protect blocks all recording
// - gap recording uses strobe trigger as clock
// - strobe trigger starts 40 us timer
// - motion_halted when tape stopped
// - motor_at_speed at 30 or 90 ips
// - upper hole decodes BOT, load, warning
// - write clock derived from base tick
// - shift register serialises write data
// - permit gates write clock and loading
// - record select picks write or read path
// - more_bytes_request asks for next byte
// - byte_assembled after eight read bits
// - read clock shifts data, times gaps
// - motor idle disables write circuits
module ctc_top #(
   parameter int TIMER_CYC = ctc_pkg::TIMER_CYC_DFLT,  // 40 us timer length
   parameter int STEP_CYC  = ctc_pkg::STEP_CYC_DFLT    // motor ramp step
) (
   // clock and reset
   input  wire logic        clk_sys,
   input  wire logic        resetn,
   // register port
   input  wire logic [7:0]  reg_addr,
   input  wire logic [31:0] reg_wdata,
   input  wire logic        reg_we,
   input  wire logic        reg_re,
   output logic      [31:0] reg_rdata,
   // pins from the drive and master timing
   input  wire logic        tape_base_tick,
   input  wire logic        read_clock_in,
   input  wire logic        read_data_in,
   input  wire logic        write_protect_in,
   input  wire logic        upper_perforation_sense,
   // motor
   output logic             backward_travel,
   output logic             motor_drive,
   output logic      [3:0]  motor_speed,
   output logic             motion_halted,
   output logic             motor_at_speed,
   output logic             motor_idle,
   // record path
   output logic             record_select,
   output logic             write_gate,
   output logic             write_clock,
   output logic             write_data,
   output logic             more_bytes_request,
   // timer
   output logic             strobe_trigger,
   output logic             timer_busy,
   // read path
   output logic      [7:0]  tape_in_byte_bus,
   output logic             byte_assembled,
   output logic             block_boundary_found
);
   ctc_wr_if wr ();
   ctc_rd_if rd ();

   logic [5:0]  ctrl_r;          // control register
   logic [4:0]  sync1_r;         // first synchroniser stage
   logic [4:0]  sync2_r;         // second stage, safe to read
   logic [4:0]  sync3_r;         // previous value for edges
   logic [15:0] timer_r;         // 40 us countdown
   logic        trig_r;          // strobe trigger pulse
   logic [19:0] step_r;          // ramp step divider
   logic [3:0]  speed_r;         // tape speed in 10 ips units
   logic [3:0]  target_w;
   logic [1:0]  pos_r;           // hole position along the tape
   logic        wclk_r;
   logic        wdat_r;
   logic        gate_r;
   logic [31:0] rdata_r;
   logic [10:0] status_w;
   logic        wr_ok_w;
   logic        step_w;
   logic        hole_rise_w;
   logic        we_ctrl_w;
   logic        we_trig_w;

   // edge finder on synchronised pins
   function automatic logic rose(input logic cur, input logic prev);
      rose = cur && !prev;
   endfunction

   // all drive pins come from another domain
   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         sync1_r <= ctc_pkg::SYNC_RST;
         sync2_r <= ctc_pkg::SYNC_RST;
         sync3_r <= ctc_pkg::SYNC_RST;
      end else begin
         sync1_r <= {upper_perforation_sense, write_protect_in, read_data_in,
                     read_clock_in, tape_base_tick};
         sync2_r <= sync1_r;
         sync3_r <= sync2_r;
      end
   end

   assign we_ctrl_w = reg_we && reg_addr == ctc_pkg::REG_CTRL;
   assign we_trig_w = reg_we && reg_addr == ctc_pkg::REG_TRIG;

   // control register
   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         ctrl_r <= ctc_pkg::CTRL_RST;
      end else if (we_ctrl_w) begin
         ctrl_r <= reg_wdata[5:0];
      end
   end

   // strobe trigger pulse and the 40 us timer; a retrigger restarts it
   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         trig_r  <= 1'b0;
         timer_r <= 16'h0000;
      end else begin
         trig_r <= we_trig_w;
         if (we_trig_w) begin
            timer_r <= 16'(TIMER_CYC);
         end else if (timer_r != 16'h0000) begin
            timer_r <= timer_r - 16'h0001;
         end
      end
   end

   // motor ramp divider, free running
   assign step_w = step_r == 20'(STEP_CYC - 1);
   always_ff @(posedge clk_sys) begin
      if (!resetn || step_w) begin
         step_r <= 20'h00000;
      end else begin
         step_r <= step_r + 20'h00001;
      end
   end

   // speed ramps one step at a time toward the target, or down to rest
   assign target_w = ctrl_r[ctc_pkg::CB_FAST] ? ctc_pkg::SPEED_FAST : ctc_pkg::SPEED_SLOW;
   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         speed_r <= 4'h0;
      end else if (step_w) begin
         if (!ctrl_r[ctc_pkg::CB_MOTOR] && speed_r != 4'h0) begin
            speed_r <= speed_r - 4'h1;
         end else if (ctrl_r[ctc_pkg::CB_MOTOR] && speed_r < target_w) begin
            speed_r <= speed_r + 4'h1;
         end else if (ctrl_r[ctc_pkg::CB_MOTOR] && speed_r > target_w) begin
            speed_r <= speed_r - 4'h1;
         end
      end
   end

   // hole decode: count holes forward, uncount backward
   assign hole_rise_w = rose(sync2_r[ctc_pkg::PIN_HOLE], sync3_r[ctc_pkg::PIN_HOLE]);
   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         pos_r <= 2'h0;
      end else if (hole_rise_w && speed_r != 4'h0) begin
         if (ctrl_r[ctc_pkg::CB_BACK] && pos_r != 2'h0) begin
            pos_r <= pos_r - 2'h1;
         end else if (!ctrl_r[ctc_pkg::CB_BACK] && pos_r != 2'h3) begin
            pos_r <= pos_r + 2'h1;
         end
      end
   end

   // write path allowed: select, permit, unprotected, motor driven
   assign wr_ok_w = ctrl_r[ctc_pkg::CB_RECSEL] && ctrl_r[ctc_pkg::CB_PERMIT]
                    && !sync2_r[ctc_pkg::PIN_PROT]
                    && ctrl_r[ctc_pkg::CB_MOTOR];

   // write clock: base tick level while a byte shifts, strobe when gapping
   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         wclk_r <= 1'b0;
         wdat_r <= 1'b0;
         gate_r <= 1'b0;
      end else begin
         gate_r <= wr_ok_w;
         wdat_r <= wr_ok_w && wr.wdata;
         if (ctrl_r[ctc_pkg::CB_GAP]) begin
            wclk_r <= wr_ok_w && trig_r;
         end else begin
            wclk_r <= wr_ok_w && wr.busy && sync2_r[ctc_pkg::PIN_TICK];
         end
      end
   end

   // serialiser hookup; data changes on the tick fall, tape strobes on rise
   assign wr.tick_fall         = rose(sync3_r[ctc_pkg::PIN_TICK], sync2_r[ctc_pkg::PIN_TICK]);
   assign wr.active            = wr_ok_w;
   assign wr.tape_out_byte_bus = reg_wdata[7:0];
   assign wr.tx_we             = reg_we && reg_addr == ctc_pkg::REG_TX;

   ctc_wr_ser u_wr (
      .clk_sys (clk_sys),
      .resetn  (resetn),
      .wr      (wr)
   );

   // deserialiser hookup; read path only when write is not selected
   assign rd.rise      = rose(sync2_r[ctc_pkg::PIN_RCLK], sync3_r[ctc_pkg::PIN_RCLK]);
   assign rd.bit_val   = sync2_r[ctc_pkg::PIN_RDAT];
   assign rd.read_mode = !ctrl_r[ctc_pkg::CB_RECSEL];
   assign rd.ack_byte  = reg_re && reg_addr == ctc_pkg::REG_RX;
   assign rd.clr_mark  = reg_we && reg_addr == ctc_pkg::REG_STATUS && reg_wdata[ctc_pkg::SB_MARK];

   ctc_rd_des u_rd (
      .clk_sys (clk_sys),
      .resetn  (resetn),
      .rd      (rd)
   );

   // status word
   always_comb begin
      status_w = 11'h000;
      status_w[ctc_pkg::SB_HALT]  = speed_r == 4'h0;
      status_w[ctc_pkg::SB_SPEED] = ctrl_r[ctc_pkg::CB_MOTOR] && speed_r == target_w;
      status_w[ctc_pkg::SB_PROT]  = sync2_r[ctc_pkg::PIN_PROT];
      status_w[ctc_pkg::SB_MORE]  = wr.more_req;
      status_w[ctc_pkg::SB_BYTE]  = rd.assembled;
      status_w[ctc_pkg::SB_MARK]  = rd.mark;
      status_w[ctc_pkg::SB_TIMER] = timer_r != 16'h0000;
      status_w[ctc_pkg::SB_BOT]   = pos_r == 2'h1;
      status_w[ctc_pkg::SB_LOAD]  = pos_r == 2'h2;
      status_w[ctc_pkg::SB_EW]    = pos_r == 2'h3;
      status_w[ctc_pkg::SB_HOLE]  = sync2_r[ctc_pkg::PIN_HOLE];
   end

   // read data stand one cycle only; unmapped reads give zero
   always_ff @(posedge clk_sys) begin
      if (!resetn || !reg_re) begin
         rdata_r <= 32'h00000000;
      end else begin
         unique case (reg_addr)
            ctc_pkg::REG_CTRL:   rdata_r <= {26'h0000000, ctrl_r};
            ctc_pkg::REG_STATUS: rdata_r <= {21'h000000, status_w};
            ctc_pkg::REG_RX:     rdata_r <= {24'h000000, rd.in_byte};
            default:             rdata_r <= 32'h00000000;
         endcase
      end
   end

   // outputs
   assign reg_rdata            = rdata_r;
   assign backward_travel      = ctrl_r[ctc_pkg::CB_BACK];
   assign motor_drive          = ctrl_r[ctc_pkg::CB_MOTOR];
   assign motor_idle           = !ctrl_r[ctc_pkg::CB_MOTOR];
   assign motor_speed          = speed_r;
   assign motion_halted        = status_w[ctc_pkg::SB_HALT];
   assign motor_at_speed       = status_w[ctc_pkg::SB_SPEED];
   assign record_select        = ctrl_r[ctc_pkg::CB_RECSEL];
   assign write_gate           = gate_r;
   assign write_clock          = wclk_r;
   assign write_data           = wdat_r;
   assign more_bytes_request   = wr.more_req;
   assign strobe_trigger       = trig_r;
   assign timer_busy           = status_w[ctc_pkg::SB_TIMER];
   assign tape_in_byte_bus     = rd.in_byte;
   assign byte_assembled       = rd.assembled;
   assign block_boundary_found = rd.mark;
endmodule
`default_nettype wire

//--- tb/ctc_drive_model.sv
`timescale 1ns/1ns
`default_nettype none
// tape drive: head, sensors and base tick
module ctc_drive_model (
   // master timing
   output logic tape_base_tick,
   // read head
   output logic read_clock_in,
   output logic read_data_in,
   // cartridge sensors
   output logic write_protect_in,
   output logic upper_perforation_sense
);
   // tick runs free: master timing never stops
   initial begin
      {tape_base_tick, read_clock_in, read_data_in, write_protect_in, upper_perforation_sense} = 5'h00;
      forever #40 tape_base_tick = ~tape_base_tick;
   end
   // one reversal per 48 ns cell
   task automatic put_bit(input logic b);
      read_data_in = b;
      #12 read_clock_in = 1'b1;
      #24 read_clock_in = 1'b0;
      #12 read_data_in = ~b;
   endtask
   // msb first
   task automatic send_byte(input logic [7:0] v);
      for (int i = 7; i >= 0; i--)
         put_bit(v[i]);
   endtask
   // quiet a little past one gap
   task automatic quiet();
      #8400;
   endtask
endmodule
`default_nettype wire

//--- tb/ctc_top_assertions.sv
`timescale 1ns/1ns
`default_nettype none
module ctc_top_chk #(
   parameter int TIMER_CYC = 20  // timer length in cycles
) (
   // clock and reset
   input wire logic       clk_sys,
   input wire logic       resetn,
   // register port
   input wire logic [7:0] reg_addr,
   input wire logic       reg_we,
   // pins and outputs
   input wire logic       write_protect_in,
   input wire logic       motor_drive,
   input wire logic [3:0] motor_speed,
   input wire logic       motion_halted,
   input wire logic       motor_at_speed,
   input wire logic       motor_idle,
   input wire logic       record_select,
   input wire logic       write_gate,
   input wire logic       write_clock,
   input wire logic       write_data,
   input wire logic       more_bytes_request,
   input wire logic       strobe_trigger,
   input wire logic       timer_busy
);
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!resetn);
   logic [15:0] busy_cnt_r;  // busy cycles so far
   // timer too long for a repetition
   always_ff @(posedge clk_sys) begin
      if (!resetn) busy_cnt_r <= 16'h0000;
      else if (strobe_trigger) busy_cnt_r <= 16'h0001;
      else if (timer_busy) busy_cnt_r <= busy_cnt_r + 16'h0001;
      else busy_cnt_r <= 16'h0000;
   end
   sequence s_trig_write;
      reg_we && reg_addr == ctc_pkg::REG_TRIG;
   endsequence
   // sync and gate settle in six cycles
   sequence s_protect_held;
      write_protect_in [*6];
   endsequence
   a_trig_starts_timer: assert property (s_trig_write |=> strobe_trigger && timer_busy)
      else $error("timer not started");
   a_timer_length: assert property ($fell(timer_busy) |-> busy_cnt_r == TIMER_CYC)
      else $error("timer span wrong");
   a_protect_blocks: assert property (s_protect_held |-> !write_gate && !write_clock)
      else $error("writing while protected");
   a_halted_zero: assert property (motion_halted == (motor_speed == 4'h0))
      else $error("halted status wrong");
   a_speed_valid: assert property (motor_at_speed |-> motor_drive && motor_speed inside {4'h3, 4'h9})
      else $error("at speed flag wrong");
   a_idle_no_write: assert property (motor_idle ##1 motor_idle |-> !write_gate && !more_bytes_request)
      else $error("write open while idle");
   a_gate_needs_sel: assert property (write_gate |-> $past(record_select))
      else $error("gate without select");
   a_closed_quiet: assert property (!write_gate [*3] |-> !write_clock && !write_data)
      else $error("clock or data while closed");
   a_more_needs_path: assert property (more_bytes_request |-> record_select && !motor_idle)
      else $error("request while closed");
endmodule
bind ctc_top ctc_top_chk #(.TIMER_CYC(TIMER_CYC)) chk_u (
   .clk_sys, .resetn, .reg_addr, .reg_we, .write_protect_in, .motor_drive, .motor_speed,
   .motion_halted, .motor_at_speed, .motor_idle, .record_select, .write_gate, .write_clock,
   .write_data, .more_bytes_request, .strobe_trigger, .timer_busy
);
`default_nettype wire

//--- tb/tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module tb_top;
   localparam int TCYC = 20;  // shortened timer
   localparam int SCYC = 8;   // shortened motor step
   logic        clk_sys, resetn, reg_we, reg_re, tape_base_tick, read_clock_in, read_data_in;
   logic        write_protect_in, upper_perforation_sense, backward_travel, motor_drive;
   logic        motion_halted, motor_at_speed, motor_idle, record_select, write_gate, write_clock;
   logic        write_data, more_bytes_request, strobe_trigger, timer_busy, byte_assembled, block_boundary_found;
   logic [3:0]  motor_speed;
   logic [7:0]  reg_addr, tape_in_byte_bus, wcap;
   logic [31:0] reg_wdata, reg_rdata, rv;
   int          mismatches, comparisons, wcnt;
   ctc_top #(.TIMER_CYC(TCYC), .STEP_CYC(SCYC)) dut_u (.*);
   ctc_drive_model drv_u (.tape_base_tick, .read_clock_in, .read_data_in, .write_protect_in,
      .upper_perforation_sense);
   initial begin
      clk_sys = 1'b0;
      forever #2 clk_sys = ~clk_sys;
   end
   // bit taken two cycles into high phase of write clock
   always @(posedge write_clock) begin
      repeat (2) @(posedge clk_sys);
      wcap = {wcap[6:0], write_data};
      wcnt++;
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         mismatches++;
         $display("[FAIL] %0t got %h exp %h", $time, got, exp);
      end
   endtask
   // strobe dropped an edge before next call
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      reg_addr <= a;
      reg_wdata <= d;
      reg_we <= 1'b1;
      @(posedge clk_sys);
      reg_we <= 1'b0;
      @(posedge clk_sys);
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      reg_addr <= a;
      reg_re <= 1'b1;
      @(posedge clk_sys);
      reg_re <= 1'b0;
      @(posedge clk_sys);
      d = reg_rdata;
   endtask
   task automatic t_reset();
      chk({motion_halted, motor_idle, byte_assembled, block_boundary_found}, 4'hc);
      rd(ctc_pkg::REG_CTRL, rv);
      chk(rv, 32'h0);
      rd(8'h14, rv);
      chk(rv, 32'h0);
   endtask
   task automatic t_timer();
      int n = 0;
      wr(ctc_pkg::REG_TRIG, 32'h1);
      chk(strobe_trigger, 1'b1);
      while (timer_busy === 1'b1 && n < 100) begin
         n++;
         @(posedge clk_sys);
      end
      chk(n, TCYC);
   endtask
   task automatic t_motor();
      wr(ctc_pkg::REG_CTRL, 32'h28);
      repeat (12 * SCYC) @(posedge clk_sys);
      chk({motor_at_speed, motion_halted, backward_travel, motor_speed}, 7'h49);
      for (int h = 1; h < 6; h++) begin
         drv_u.upper_perforation_sense <= h[0];
         repeat (8) @(posedge clk_sys);
         rd(ctc_pkg::REG_STATUS, rv);
         chk(rv[10:7], {h[0], 3'(1 << ((h - 1) / 2))});
      end
      wr(ctc_pkg::REG_CTRL, 32'h29);
      chk(backward_travel, 1'b1);
      wr(ctc_pkg::REG_CTRL, 32'h0);
      repeat (12 * SCYC) @(posedge clk_sys);
      chk({motion_halted, motor_speed}, 5'h10);
   endtask
   task automatic t_read();
      wr(ctc_pkg::REG_CTRL, 32'h08);
      drv_u.send_byte(8'ha5);
      repeat (8) @(posedge clk_sys);
      chk({byte_assembled, tape_in_byte_bus}, 9'h1a5);
      rd(ctc_pkg::REG_RX, rv);
      chk(rv, 32'ha5);
      chk(byte_assembled, 1'b0);
      // four gaps, one reversal between neighbours
      for (int g = 1; g <= 4; g++) begin
         drv_u.quiet();
         chk(block_boundary_found, g == 4);
         if (g < 4) drv_u.put_bit(1'b1);
      end
      drv_u.send_byte(8'h5a);
      repeat (8) @(posedge clk_sys);
      chk({byte_assembled, tape_in_byte_bus}, 9'h15a);
      resetn <= 1'b0;
      repeat (3) @(posedge clk_sys);
      resetn <= 1'b1;
      @(posedge clk_sys);
      chk({byte_assembled, block_boundary_found}, 2'b00);
   endtask
   task automatic t_write();
      wr(ctc_pkg::REG_CTRL, 32'h0e);
      chk(more_bytes_request, 1'b1);
      @(negedge tape_base_tick);
      @(posedge clk_sys);
      wcnt = 0;
      wr(ctc_pkg::REG_TX, 32'h96);
      for (int i = 0; i < 300 && wcnt < 8; i++) @(posedge clk_sys);
      chk(wcap, 8'h96);
      wr(ctc_pkg::REG_CTRL, 32'h0a);
      @(posedge clk_sys);
      wcnt = 0;
      chk({write_gate, more_bytes_request}, 2'b00);
      repeat (50) @(posedge clk_sys);
      chk(wcnt, 0);
   endtask
   task automatic t_gap();
      wr(ctc_pkg::REG_CTRL, 32'h1e);
      wcnt = 0;
      wr(ctc_pkg::REG_TRIG, 32'h1);
      repeat (10) @(posedge clk_sys);
      chk(wcnt, 1);
   endtask
   task automatic t_protect();
      drv_u.write_protect_in <= 1'b1;
      repeat (6) @(posedge clk_sys);
      chk({write_gate, more_bytes_request}, 2'b00);
      rd(ctc_pkg::REG_STATUS, rv);
      chk(rv[ctc_pkg::SB_PROT], 1'b1);
      drv_u.write_protect_in <= 1'b0;
      repeat (5) @(posedge clk_sys);
      chk(write_gate, 1'b1);
      wr(ctc_pkg::REG_CTRL, 32'h16);
      @(posedge clk_sys);
      chk({motor_idle, write_gate}, 2'b10);
   endtask
   task automatic give_verdict();
      $display("comparisons %0d mismatches %0d", comparisons, mismatches);
      if (mismatches == 0 && comparisons > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   // watchdog well past the run
   initial begin
      #300000;
      mismatches++;
      give_verdict();
   end
   initial begin
      {mismatches, comparisons, wcnt} = '0;
      {resetn, reg_we, reg_re, reg_addr, reg_wdata} = '0;
      repeat (16) @(posedge clk_sys);
      resetn <= 1'b1;
      @(posedge clk_sys);
      t_reset();
      t_timer();
      t_motor();
      t_read();
      t_write();
      t_gap();
      t_protect();
      give_verdict();
   end
endmodule
`default_nettype wire
